/* File: dbps_seq.sv */
`timescale 1ns/10ps
// Functional notes
// - shifts never change condition codes
// - shift amount from constant or register
// - set-high: 22 bits high, low ten zero
// - nonzero tag on either operand sets overflow
// - trapping tagged ops set codes, trap on tag overflow
// - delay instruction always fetched
// - transfer kinds: relative/indirect, delayed or not
// - relative target is pc plus shifted displacement
// - indirect target is rs1 plus rs2 or immediate
// - delayed transfer redirects after one instruction
// - pc takes pointer; pointer steps four or target
// - back-to-back: first target is delay address
// - annul honoured on conditional branches only
// - untaken annulled branch skips delay instruction
// - annulled instruction changes nothing, never traps
// - taken conditional branch other than branch-always ignores annul bit
// - branch-always annul skips delay when taken
// - register zero: writes discarded, last result kept
module dbps_seq (
  input  wire logic        CLK_IN,
  input  wire logic        RESET_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HSEL_IN,
  input  wire logic        HREADY_IN,
  output logic      [31:0] HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  output logic      [31:0] FETCH_ADDR_OUT,
  output logic             IRQ_OUT
);
  import dbps_pkg::*;

  // processor state
  logic [31:0]   pc_q;          // instruction being executed
  logic [31:0]   nfp_q;         // next_fetch_pointer
  logic [3:0]    icc_q;         // n z v c
  logic          annul_q;       // next instruction is annulled
  logic [31:0]   res_q;         // last destination write, unchanged by a write to r0
  logic [31:0]   src1_q;        // first_source_reg value
  logic [31:0]   src2_q;        // second_source_reg value
  logic [EV_W-1:0] stat_q;      // sticky events
  logic [EV_W-1:0] ien_q;       // event enables
  logic          en_q;          // sequencer enable
  dbps_state_t   st_q;

  // bus address phase capture
  logic          wr_pend_q;
  logic [7:0]    a_q;
  logic          rd_ok;
  logic [31:0]   rd_mux;

  // execute path
  dbps_instr_t   ins;
  logic          issue;
  logic [31:0]   opb;
  logic [31:0]   res_d;
  logic          wr_res;
  logic [3:0]    icc_d;
  logic          xfer;
  logic          trap;
  logic          annul_d;
  logic [31:0]   target;
  logic [31:0]   disp_ext;      // sign-extended branch displacement
  logic [31:0]   trap_pc;       // register-indirect trap target
  logic          cond_ok;
  logic          is_ba;
  logic [EV_W-1:0] ev;

  // sign-extend a field of given width, used for displacement and short immediate
  function automatic logic [31:0] sext(input logic [22:0] v, input int w);
    logic [31:0] r;
    r = 32'h0;
    for (int k = 0; k < 32; k++) begin
      r[k] = (k < w) ? v[k] : v[w-1];
    end
    return r;
  endfunction

  // address phase: zero-wait slave, writes commit in data phase
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      wr_pend_q <= 1'b0;
      a_q       <= 8'h00;
    end else if (HREADY_IN) begin
      wr_pend_q <= HSEL_IN & HTRANS_IN[1] & HWRITE_IN;
      a_q       <= HADDR_IN[7:0];
    end
  end

  assign ins   = dbps_instr_t'(HWDATA_IN);
  assign issue = wr_pend_q & (a_q == INSTR_OFF) & en_q & (st_q == ST_RUN);

  // condition evaluation; cond 1 is branch-always
  always_comb begin
    case (ins.cond)
      2'd0:    cond_ok = 1'b0;
      2'd1:    cond_ok = 1'b1;
      2'd2:    cond_ok = icc_q[2];
      default: cond_ok = ~icc_q[2];
    endcase
  end
  assign is_ba = (ins.cond == 2'd1);
  // second operand: register or signed short immediate
  assign opb = ins.imm_sel ? sext(ins.payload, 13) : src2_q;
  // a part-select of a function call is illegal, so extend once here
  assign disp_ext = sext(ins.payload, 22);
  assign trap_pc  = src1_q + opb;

  // execution of one issued instruction
  always_comb begin
    res_d   = res_q;
    wr_res  = 1'b0;
    icc_d   = icc_q;
    xfer    = 1'b0;
    trap    = 1'b0;
    annul_d = 1'b0;
    target  = nfp_q + PC_STEP;
    case (ins.op)
      OP_SLL: begin
        res_d  = src1_q << opb[4:0];
        wr_res = 1'b1;
      end
      OP_SRL: begin
        res_d  = src1_q >> opb[4:0];
        wr_res = 1'b1;
      end
      OP_SRA: begin
        res_d  = $signed(src1_q) >>> opb[4:0];
        wr_res = 1'b1;
      end
      OP_SET_HIGH: begin
        res_d  = {ins.payload[21:0], 10'h000};
        wr_res = 1'b1;
      end
      OP_TADD, OP_TSUB, OP_TADDTV, OP_TSUBTV: begin
        res_d    = (ins.op == OP_TADD || ins.op == OP_TADDTV) ? src1_q + opb : src1_q - opb;
        wr_res   = 1'b1;
        icc_d[3] = res_d[31];
        icc_d[2] = (res_d == 32'h0);
        icc_d[1] = (|src1_q[1:0]) | (|opb[1:0]);
        icc_d[0] = 1'b0;
        trap     = icc_d[1] & (ins.op == OP_TADDTV || ins.op == OP_TSUBTV);
      end
      OP_BR: begin
        xfer   = cond_ok;
        target = pc_q + {disp_ext[29:0], 2'b00};
        // annul only here: untaken, or taken branch-always
        annul_d = ins.annul & (is_ba ? cond_ok : ~cond_ok);
      end
      OP_CALL: begin
        xfer   = 1'b1;
        target = pc_q + {disp_ext[29:0], 2'b00};
      end
      OP_JUMP_LINK, OP_TRAP_RET: begin
        xfer   = 1'b1;
        target = trap_pc;
      end
      OP_TRAP: begin
        trap   = cond_ok;                           // not delayed
      end
      default: begin
      end
    endcase
  end

  // state machine: idle until enabled
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) st_q <= ST_IDLE;
    else begin
      case (st_q)
        ST_IDLE: if (en_q) st_q <= ST_RUN;
        ST_RUN:  if (!en_q) st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // pc / pointer sequencing; a trap is not delayed and jumps at once
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      pc_q    <= PC_RST;
      nfp_q   <= NFP_RST;
      annul_q <= 1'b0;
    end else if (issue) begin
      if (annul_q) begin
        pc_q    <= nfp_q;                           // only advances
        nfp_q   <= nfp_q + PC_STEP;
        annul_q <= 1'b0;
      end else if (trap) begin
        pc_q    <= trap_pc;                         // register-indirect, no delay
        nfp_q   <= trap_pc + PC_STEP;
        annul_q <= 1'b0;
      end else begin
        pc_q    <= nfp_q;
        nfp_q   <= xfer ? target : nfp_q + PC_STEP;
        annul_q <= annul_d;
      end
    end
  end

  // datapath results; annulled instructions touch nothing
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      res_q <= 32'h0;
      icc_q <= 4'h0;
    end else if (issue && !annul_q) begin
      icc_q <= icc_d;                               // shifts leave icc_d = icc_q
      // destination zero: result discarded, res_q keeps the last result
      if (wr_res && ins.payload[22:18] != 5'd0) res_q <= res_d;
    end
  end

  // software-held operand values, sequencer enable and event enables
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      src1_q <= 32'h0;
      src2_q <= 32'h0;
      en_q   <= 1'b0;
      ien_q  <= '0;
    end else if (wr_pend_q) begin
      if (a_q == ISRC_OFF) src1_q <= HWDATA_IN;
      if (a_q == IOPB_OFF) src2_q <= HWDATA_IN;
      if (a_q == CTRL_OFF) en_q  <= HWDATA_IN[0];
      if (a_q == IEN_OFF)  ien_q <= HWDATA_IN[EV_W-1:0];
    end
  end

  // sticky events; a new event wins over a clear in the same cycle
  assign ev = {issue & !annul_q & xfer,
               issue & annul_q,
               issue & !annul_q & trap};
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) stat_q <= '0;
    else begin
      if (wr_pend_q && a_q == CLR_OFF) stat_q <= (stat_q & ~HWDATA_IN[EV_W-1:0]) | ev;
      else stat_q <= stat_q | ev;
    end
  end

  // read mux; unmapped reads return zero
  always_comb begin
    rd_mux = 32'h0;
    case (HADDR_IN[7:0])
      PC_OFF:    rd_mux = pc_q;
      NFP_OFF:   rd_mux = nfp_q;
      RES_OFF:   rd_mux = res_q;
      FLAGS_OFF: rd_mux = {27'h0, annul_q, icc_q};
      STAT_OFF:  rd_mux = {29'h0, stat_q};
      IEN_OFF:   rd_mux = {29'h0, ien_q};
      CTRL_OFF:  rd_mux = {31'h0, en_q};
      default:   rd_mux = 32'h0;
    endcase
  end
  assign rd_ok = HREADY_IN & HSEL_IN & HTRANS_IN[1] & ~HWRITE_IN;

  // registered outputs
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      HRDATA_OUT     <= 32'h0;
      HREADYOUT_OUT  <= 1'b1;
      HRESP_OUT      <= 1'b0;
      FETCH_ADDR_OUT <= NFP_RST;
      IRQ_OUT        <= 1'b0;
    end else begin
      if (rd_ok) HRDATA_OUT <= rd_mux;
      HREADYOUT_OUT  <= 1'b1;
      HRESP_OUT      <= 1'b0;
      FETCH_ADDR_OUT <= nfp_q;                     // delay slot is always fetched
      IRQ_OUT        <= |(stat_q & ien_q);
    end
  end

  // checks
  a_npc_step: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    issue && !annul_q && !trap && !xfer |=> nfp_q == $past(nfp_q) + 32'h4)
    else $error("pointer did not step by four");
  a_pc_takes_ptr: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    issue && !trap |=> pc_q == $past(nfp_q))
    else $error("pc did not take pointer");
  a_annul_freeze: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    issue && annul_q |=> $stable(icc_q) && $stable(res_q) && !annul_q)
    else $error("annulled instruction changed state");
  a_shift_icc: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    issue && ins.op inside {OP_SLL, OP_SRL, OP_SRA} |=> $stable(icc_q))
    else $error("shift changed condition codes");
  a_set_high_const_low: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    issue && !annul_q && ins.op == OP_SET_HIGH && ins.payload[22:18] != 5'd0
    |=> res_q[9:0] == 10'h000 && $stable(icc_q))
    else $error("set-high low bits not zero");
  a_tag_ovf: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    issue && !annul_q && ins.op inside {OP_TADD, OP_TSUB} && (|src1_q[1:0])
    |=> icc_q[1])
    else $error("tag overflow not set");
  a_taken_noannul: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    issue && !annul_q && ins.op == OP_BR && cond_ok && !is_ba |=> !annul_q)
    else $error("taken branch annulled delay");
  a_untaken_annul: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    issue && !annul_q && ins.op == OP_BR && ins.annul && !cond_ok && !is_ba
    |=> annul_q)
    else $error("untaken annul branch did not annul");
  a_irq_level: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    |(stat_q & ien_q) |=> IRQ_OUT)
    else $error("interrupt not raised");
  a_ba_annul: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    issue && !annul_q && ins.op == OP_BR && ins.annul && is_ba |=> annul_q)
    else $error("branch-always annul did not skip delay");
  a_jump_noannul: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    issue && !annul_q && ins.op inside {OP_CALL, OP_JUMP_LINK, OP_TRAP_RET}
    |=> !annul_q)
    else $error("non-branch transfer annulled delay");
  a_trap_direct: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    issue && !annul_q && trap |=> pc_q == $past(trap_pc))
    else $error("trap did not jump at once");
  a_zero_discard: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    issue && !annul_q && wr_res && ins.payload[22:18] == 5'd0 |=> $stable(res_q))
    else $error("write to register zero kept");
endmodule

/* File: dbps_pkg.sv */
package dbps_pkg;
  // register map (byte addresses)
  localparam logic [7:0] CTRL_OFF    = 8'h00;  // rw: sequencer enable
  localparam logic [7:0] INSTR_OFF   = 8'h04;  // w: issue one instruction
  localparam logic [7:0] ISRC_OFF    = 8'h08;  // w: first source register value
  localparam logic [7:0] IOPB_OFF    = 8'h0c;  // w: second register value
  localparam logic [7:0] PC_OFF      = 8'h10;  // r: program counter
  localparam logic [7:0] NFP_OFF     = 8'h14;  // r: next fetch pointer
  localparam logic [7:0] RES_OFF     = 8'h18;  // r: last result
  localparam logic [7:0] FLAGS_OFF   = 8'h1c;  // r: nzvc + annul pending
  localparam logic [7:0] STAT_OFF    = 8'h20;  // r: sticky events
  localparam logic [7:0] CLR_OFF     = 8'h24;  // w1c: event clear
  localparam logic [7:0] IEN_OFF     = 8'h28;  // rw: event enable
  // reset values
  localparam logic [31:0] PC_RST     = 32'h0000_0000;
  localparam logic [31:0] NFP_RST    = 32'h0000_0004;
  localparam logic [31:0] PC_STEP    = 32'h0000_0004;
  // event bits
  localparam int EV_TRAP    = 0;   // trap taken: tagged overflow or trap instruction
  localparam int EV_ANNUL   = 1;   // delay instruction annulled
  localparam int EV_XFER    = 2;   // control transfer taken
  localparam int EV_W       = 3;
  // operation codes in INSTR[31:27]
  typedef enum logic [4:0] {
    OP_NOP     = 5'h00,
    OP_SLL     = 5'h01,
    OP_SRL     = 5'h02,
    OP_SRA     = 5'h03,
    OP_SET_HIGH = 5'h04, // set_high_const
    OP_TADD    = 5'h05,  // tag_add_flags
    OP_TSUB    = 5'h06,  // tag_sub_flags
    OP_TADDTV  = 5'h07,  // tag_add_trapping
    OP_TSUBTV  = 5'h08,  // tag_sub_trapping
    OP_BR      = 5'h09,  // integer conditional branch
    OP_CALL    = 5'h0a,
    OP_JUMP_LINK = 5'h0b,  // jump_and_link
    OP_TRAP_RET  = 5'h0c,  // trap_return
    OP_TRAP    = 5'h0d
  } dbps_op_t;
  // decoded instruction fields
  typedef struct packed {
    dbps_op_t    op;       // [31:27]
    logic        annul;    // [26]
    logic        imm_sel;  // [25] i bit
    logic [1:0]  cond;     // [24:23] 0 never,1 always,2 z,3 !z
    logic [22:0] payload;  // displacement / constant / short immediate / shift count
  } dbps_instr_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } dbps_state_t;
endpackage

/* File: dbps_imem.sv */
`timescale 1ns/10ps
// instruction memory on the far side: answers a fetch address one cycle later
module dbps_imem (
  input  wire logic        clk_in,
  input  wire logic [31:0] fetch_addr_in,
  output logic      [31:0] word_out
);
  logic [31:0] mem [64];  // program words, loaded by the bench before reset ends
  // the delay slot word is fetched at every pointer, branch or not
  always_ff @(posedge clk_in) begin
    word_out <= mem[fetch_addr_in[7:2]];
  end
endmodule

/* File: dbps_seq_test.sv */
`timescale 1ns/10ps
module delayed_branch_pc_sequencer_test;
  import dbps_pkg::*;
  logic        clk = 1'b0;      // 100 MHz bench clock
  logic        rst = 1'b1;      // synchronous reset
  logic [31:0] haddr = '0;      // bus master outputs
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic        hsel = 1'b0;
  logic [31:0] hrdata;
  logic [31:0] fetch;
  logic [31:0] iword;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic [31:0] exp_q[$];        // notes: expected read data
  logic [31:0] msk_q[$];        // notes: bits that matter
  logic [31:0] adr_q[$];        // notes: which register
  logic [31:0] cur;             // word to issue next
  logic [31:0] nxt;             // word already fetched behind it
  logic [31:0] src;             // random first operand
  integer      seed = 32'h56d4;
  int          n_mismatch = 0;
  int          checked = 0;
  bit          rd_dp = 1'b0;    // a read data phase is under way

  always #5 clk = ~clk;

  dbps_seq u_dut (
    .CLK_IN(clk), .RESET_IN(rst), .HADDR_IN(haddr), .HTRANS_IN(htrans),
    .HWRITE_IN(hwrite), .HSIZE_IN(3'b010), .HWDATA_IN(hwdata), .HSEL_IN(hsel),
    .HREADY_IN(hreadyout), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hreadyout),
    .HRESP_OUT(hresp), .FETCH_ADDR_OUT(fetch), .IRQ_OUT(irq)
  );
  dbps_imem u_imem (.clk_in(clk), .fetch_addr_in(fetch), .word_out(iword));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (n_mismatch == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) n_mismatch++;
  endtask

  // one single word transfer; for a read, d is the expected value under mask m
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsel <= 1'b1;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= w ? d : 32'h0;
    if (!w) begin
      exp_q.push_back(d);
      msk_q.push_back(m);
      adr_q.push_back({24'h0, a});
    end
    wait_rdy();
  endtask

  task automatic pcs(input logic [31:0] p, input logic [31:0] np);
    xfer(1'b0, PC_OFF, p, '1);
    xfer(1'b0, NFP_OFF, np, '1);
  endtask

  // issue the word at pc; the word behind it was fetched from the pointer
  task automatic step();
    xfer(1'b1, INSTR_OFF, cur, '0);
    cur = nxt;
    repeat (3) @(posedge clk);
    nxt = iword;
  endtask

  function automatic logic [31:0] ins(dbps_op_t op, logic a, logic i, logic [1:0] c,
                                      logic [22:0] p);
    return {op, a, i, c, p};
  endfunction

  // monitor: each finished read data phase takes the oldest note
  always @(posedge clk) begin
    logic [31:0] e;
    logic [31:0] m;
    logic [31:0] a;
    if (rd_dp && hreadyout === 1'b1) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      a = adr_q.pop_front();
      check(hrdata & m, e & m, $sformatf("reg_%h", a[7:0]));
    end
    if (hreadyout === 1'b1) rd_dp = hsel && htrans[1] && !hwrite;
  end

  // watchdog, far beyond the two hundred or so cycles the run needs
  initial begin
    #200000;
    n_mismatch++;
    end_of_test();
  end

  initial begin
    src = ($random(seed) & 32'h3c);
    u_imem.mem[0] = ins(OP_NOP, 1'b0, 1'b0, 2'd0, 23'h0);
    u_imem.mem[1] = ins(OP_BR, 1'b0, 1'b0, 2'd1, 23'd6);
    u_imem.mem[2] = ins(OP_SET_HIGH, 1'b0, 1'b0, 2'd0, {1'b1, 22'h2abcde});
    u_imem.mem[7] = ins(OP_SET_HIGH, 1'b0, 1'b0, 2'd0, 23'h001234);
    u_imem.mem[8] = ins(OP_BR, 1'b1, 1'b0, 2'd0, 23'd9);
    u_imem.mem[9] = ins(OP_SET_HIGH, 1'b0, 1'b0, 2'd0, {1'b1, 22'h155555});
    u_imem.mem[10] = ins(OP_BR, 1'b1, 1'b0, 2'd1, 23'd4);
    u_imem.mem[11] = u_imem.mem[9];
    u_imem.mem[14] = ins(OP_JUMP_LINK, 1'b0, 1'b0, 2'd0, 23'h0);
    u_imem.mem[15] = ins(OP_JUMP_LINK, 1'b0, 1'b1, 2'd0, {10'h0, 13'h1ff0});
    u_imem.mem[(src + 32'h40) >> 2] = u_imem.mem[0];
    u_imem.mem[48] = ins(OP_TADD, 1'b0, 1'b0, 2'd0, {5'h10, 18'h0});
    u_imem.mem[49] = ins(OP_SLL, 1'b0, 1'b1, 2'd0, {5'h10, 5'h0, 13'h0004});
    u_imem.mem[50] = ins(OP_SRL, 1'b0, 1'b0, 2'd0, {5'h10, 18'h0});
    u_imem.mem[51] = ins(OP_TADDTV, 1'b0, 1'b0, 2'd0, {5'h10, 18'h0});
    u_imem.mem[52] = ins(OP_TRAP, 1'b0, 1'b1, 2'd1, {10'h0, 13'h0008});
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cur = u_imem.mem[0];
    nxt = iword;
    pcs(PC_RST, NFP_RST);
    xfer(1'b0, 8'h3c, 32'h0, '1);                           // unmapped place reads zero
    xfer(1'b1, CTRL_OFF, 32'h1, '0);
    xfer(1'b1, IEN_OFF, 32'h1, '0);
    step();
    pcs(32'h4, 32'h8);
    step();
    pcs(32'h8, 32'h1c);
    xfer(1'b0, STAT_OFF, 32'h4, 32'h4);
    step();
    pcs(32'h1c, 32'h20);
    xfer(1'b0, RES_OFF, {22'h2abcde, 10'h0}, '1);
    step();
    xfer(1'b0, RES_OFF, {22'h2abcde, 10'h0}, '1);
    repeat (2) step();
    pcs(32'h28, 32'h2c);
    xfer(1'b0, RES_OFF, {22'h2abcde, 10'h0}, '1);
    xfer(1'b0, STAT_OFF, 32'h2, 32'h2);
    repeat (2) step();
    pcs(32'h38, 32'h3c);
    xfer(1'b0, RES_OFF, {22'h2abcde, 10'h0}, '1);
    xfer(1'b1, ISRC_OFF, src, '0);
    xfer(1'b1, IOPB_OFF, 32'h40, '0);
    step();
    pcs(32'h3c, src + 32'h40);
    xfer(1'b1, ISRC_OFF, 32'hd0, '0);
    step();
    pcs(src + 32'h40, 32'hc0);
    step();
    pcs(32'hc0, 32'hc4);
    xfer(1'b1, ISRC_OFF, 32'h5, '0);
    xfer(1'b1, IOPB_OFF, 32'h8, '0);
    step();
    xfer(1'b0, FLAGS_OFF, 32'h2, 32'h2);
    xfer(1'b0, STAT_OFF, 32'h0, 32'h1);
    step();
    xfer(1'b0, RES_OFF, 32'h50, '1);
    xfer(1'b0, FLAGS_OFF, 32'h2, 32'hf);
    xfer(1'b1, IOPB_OFF, 32'h1, '0);
    step();
    xfer(1'b0, RES_OFF, 32'h2, '1);
    check(irq, 1'b0, "irq");
    xfer(1'b1, IOPB_OFF, 32'h8, '0);
    step();
    check(irq, 1'b1, "irq");
    xfer(1'b0, STAT_OFF, 32'h1, 32'h1);
    xfer(1'b1, IEN_OFF, 32'h0, '0);
    repeat (2) @(posedge clk);
    check(irq, 1'b0, "irq");                                // masked event stays quiet
    xfer(1'b1, CLR_OFF, 32'h1, '0);
    xfer(1'b1, IEN_OFF, 32'h1, '0);
    repeat (2) @(posedge clk);
    check(irq, 1'b0, "irq");                                // cleared event stays quiet
    xfer(1'b1, ISRC_OFF, 32'h80, '0);
    step();
    xfer(1'b0, PC_OFF, 32'h88, '1);
    repeat (2) @(posedge clk);
    end_of_test();
  end
endmodule
